// ==== include/dram_ctl_regs.vh ====
// Register map, field positions, reset values, write key and shift counts of the
// DRAM control block. Definitions only; included by the design file.
`ifndef DRAM_CTL_REGS_VH
`define DRAM_CTL_REGS_VH

// ****************************************************************
// Word indices (ADDRESS[3:2]) on the register bus
// ****************************************************************
`define OFS_AREA_CTRL      2'h0
`define OFS_REFRESH_CTRL   2'h1
`define OFS_AUX_CTRL       2'h2
`define OFS_STATUS         2'h3

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_DUAL_STROBE    15
`define BIT_ROW_HOLD       14
`define BIT_PRECHARGE      13
`define BIT_BURST          12
`define BIT_CAS_DUTY       11
`define BIT_MUX_EN         10
`define BIT_SHIFT_HI       9
`define BIT_SHIFT_LO       8
`define BIT_RFSH_EN        7
`define BIT_RFSH_KIND      6
`define BIT_RWAIT_HI       5
`define BIT_RWAIT_LO       4
`define BIT_DRAM_EN        0
`define BIT_RWAIT_EN       1

// ****************************************************************
// Reset values, write key and shift counts
// ****************************************************************
`define RST_AREA_CTRL      8'h00
`define RST_REFRESH_CTRL   4'h0
`define RST_AUX_CTRL       2'h0
`define REFRESH_KEY        8'h5A
`define SHIFT_8            5'h08
`define SHIFT_9            5'h09
`define SHIFT_10           5'h0A

`endif

// ==== rtl/dram_ctl.v ====
// DRAM strobe sequencer with its area control and refresh control registers.
// Assumes a core that holds REQ until ACK, a refresh timer that pulses
// REFRESH_MATCH on compare match, and a pad cell that shapes the short duty.
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

// ****************************************************************
// Module dram_ctl
// ****************************************************************
module dram_ctl #(
  parameter ADDR_W = 28
) (
  input  wire              REF_CLK,
  input  wire              RESET_N,
  input  wire [3:0]        ADDRESS,
  input  wire              READ,
  input  wire              WRITE,
  input  wire [31:0]       WRITEDATA,
  input  wire [3:0]        BYTEENABLE,
  output reg  [31:0]       READDATA,
  output reg               WAITREQUEST,
  input  wire              REQ,
  input  wire [ADDR_W-1:0] REQ_ADDR,
  input  wire              REQ_WRITE,
  input  wire              REQ_WIDE,
  input  wire              REQ_HI,
  input  wire              REQ_LO,
  output reg               ACK,
  input  wire              REFRESH_MATCH,
  output reg               RAS_N,
  output reg               COLUMN_STROBE_HIGH_N,
  output reg               COLUMN_STROBE_LOW_N,
  output reg               WRH_N,
  output reg               WRL_N,
  output reg  [ADDR_W-1:0] DRAM_ADDR,
  output reg               CAS_SHORT_DUTY
);

`include "dram_ctl_regs.vh"

  localparam S_IDLE = 3'h0;
  localparam S_PRE  = 3'h1;
  localparam S_ROW  = 3'h2;
  localparam S_COL  = 3'h3;
  localparam S_CBRC = 3'h4;
  localparam S_CBRR = 3'h5;
  localparam S_SELF = 3'h6;
  localparam S_CBRW = 3'h7;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [7:0]        area_reg;
  reg  [3:0]        rfsh_reg;
  reg  [1:0]        aux_reg;
  reg  [2:0]        state_reg;
  reg  [2:0]        state_next;
  reg  [1:0]        cnt_reg;
  reg  [1:0]        cnt_next;
  reg               pend_reg;
  reg               open_reg;
  reg               open_next;
  reg  [ADDR_W-1:0] row_reg;
  reg               ras_next;
  reg               column_strobe_high_next;
  reg               column_strobe_low_next;
  reg               wrh_next;
  reg               wrl_next;
  reg               ack_next;
  reg  [ADDR_W-1:0] addr_next;

  wire dual_we     = area_reg[`BIT_DUAL_STROBE - 8];
  wire row_hold    = area_reg[`BIT_ROW_HOLD - 8];
  wire pre_long    = area_reg[`BIT_PRECHARGE - 8];
  wire burst_en    = area_reg[`BIT_BURST - 8];
  wire cas_duty    = area_reg[`BIT_CAS_DUTY - 8];
  wire mux_en      = area_reg[`BIT_MUX_EN - 8];
  wire [1:0] shift = area_reg[`BIT_SHIFT_HI - 8:`BIT_SHIFT_LO - 8];
  wire rfsh_en     = rfsh_reg[`BIT_RFSH_EN - 4];
  wire rfsh_kind   = rfsh_reg[`BIT_RFSH_KIND - 4];
  wire [1:0] rwait = rfsh_reg[`BIT_RWAIT_HI - 4:`BIT_RWAIT_LO - 4];
  wire dram_en     = aux_reg[`BIT_DRAM_EN];
  wire rwait_en    = aux_reg[`BIT_RWAIT_EN];

  // ****************************************************************
  // Row address helpers
  // ****************************************************************
  // The reserved shift code behaves as the 8-bit code so that nothing
  // undefined reaches the pins.
  function [4:0] shift_of;
    input [1:0] code;
    begin
      case (code)
        2'h1:    shift_of = `SHIFT_9;
        2'h2:    shift_of = `SHIFT_10;
        default: shift_of = `SHIFT_8;
      endcase
    end
  endfunction

  function [ADDR_W-1:0] row_bits;
    input [ADDR_W-1:0] a;
    input [1:0]        code;
    begin
      row_bits = (a >> shift_of(code)) << shift_of(code);
    end
  endfunction

  wire row_hit = (row_bits(REQ_ADDR, shift) == row_bits(row_reg, shift));
  wire [ADDR_W-1:0] row_out = mux_en ? (REQ_ADDR >> shift_of(shift)) : REQ_ADDR;
  wire want_self = rfsh_en & rfsh_kind;
  wire req_live  = REQ & ~ACK;

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  wire [1:0] widx   = ADDRESS[3:2];
  wire       wr_go  = WRITE & ~WAITREQUEST;
  wire       key_ok = (BYTEENABLE[1:0] == 2'h3) & (WRITEDATA[15:8] == `REFRESH_KEY);

  function [31:0] rd_mux;
    input [1:0] idx;
    begin
      case (idx)
        `OFS_AREA_CTRL:    rd_mux = {16'h0000, area_reg, 8'h00};
        `OFS_REFRESH_CTRL: rd_mux = {24'h000000, rfsh_reg, 4'h0};
        `OFS_AUX_CTRL:     rd_mux = {30'h00000000, aux_reg};
        `OFS_STATUS:       rd_mux = {26'h0000000, pend_reg, open_reg,
                                     want_self, state_reg};
        default:           rd_mux = 32'h00000000;
      endcase
    end
  endfunction

  always @(posedge REF_CLK) begin
    if (!RESET_N) begin
      WAITREQUEST <= 1'b1;
      READDATA    <= 32'h00000000;
      area_reg    <= `RST_AREA_CTRL;
      rfsh_reg    <= `RST_REFRESH_CTRL;
      aux_reg     <= `RST_AUX_CTRL;
    end else begin
      // One wait cycle per access: read data is captured while the
      // request stands, then waitrequest drops for exactly one edge.
      if ((READ | WRITE) & WAITREQUEST) begin
        WAITREQUEST <= 1'b0;
        READDATA    <= READ ? rd_mux(widx) : 32'h00000000;
      end else begin
        WAITREQUEST <= 1'b1;
      end
      if (wr_go && widx == `OFS_AREA_CTRL && BYTEENABLE[1]) begin
        area_reg <= WRITEDATA[15:8];
      end
      if (wr_go && widx == `OFS_REFRESH_CTRL && key_ok) begin
        rfsh_reg <= WRITEDATA[7:4];
      end
      if (wr_go && widx == `OFS_AUX_CTRL && BYTEENABLE[0]) begin
        aux_reg <= WRITEDATA[1:0];
      end
    end
  end

  // ****************************************************************
  // Refresh request latch
  // ****************************************************************
  // A match in the same cycle as the start of a refresh is kept.
  always @(posedge REF_CLK) begin
    if (!RESET_N) begin
      pend_reg <= 1'b0;
    end else if (REFRESH_MATCH & rfsh_en & ~rfsh_kind) begin
      pend_reg <= 1'b1;
    end else if (state_next == S_CBRC || !rfsh_en || rfsh_kind) begin
      pend_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Strobe sequencer
  // ****************************************************************
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    open_next  = open_reg;
    ras_next   = ~open_reg;
    column_strobe_high_next  = 1'b1;
    column_strobe_low_next  = 1'b1;
    wrh_next   = 1'b1;
    wrl_next   = 1'b1;
    ack_next   = 1'b0;
    addr_next  = DRAM_ADDR;
    case (state_reg)
      S_IDLE: begin
        if (pend_reg & rfsh_en & ~rfsh_kind) begin
          state_next = open_reg ? S_PRE : S_CBRC;
        end else if (want_self) begin
          state_next = open_reg ? S_PRE : S_SELF;
        end else if (req_live & ~dram_en) begin
          ack_next = 1'b1;
          if (open_reg) begin
            state_next = S_PRE;
          end
        end else if (req_live) begin
          if (open_reg & burst_en & row_hit) begin
            state_next = S_COL;
          end else if (open_reg) begin
            state_next = S_PRE;
          end else begin
            state_next = S_ROW;
          end
        end else if (open_reg & ~row_hold) begin
          state_next = S_PRE;
        end
        if (state_next == S_PRE) begin
          cnt_next  = {1'b0, pre_long};
          open_next = 1'b0;
          ras_next  = 1'b1;
        end else if (state_next == S_ROW) begin
          addr_next = row_out;
          ras_next  = 1'b1;
        end else if (state_next == S_CBRC || state_next == S_SELF) begin
          column_strobe_low_next = 1'b0;
          column_strobe_high_next = 1'b0;
        end else if (state_next == S_COL) begin
          state_next = S_ROW;
          open_next  = 1'b1;
          ras_next   = 1'b0;
          addr_next  = REQ_ADDR;
        end
        if (state_next == S_ROW && open_reg) begin
          // Burst hit: jump straight to the column phase.
          state_next = S_COL;
          addr_next  = REQ_ADDR;
          ras_next   = 1'b0;
          if (REQ_WIDE & ~dual_we) begin
            column_strobe_high_next = ~REQ_HI;
            column_strobe_low_next = ~REQ_LO;
            wrl_next  = ~REQ_WRITE;
          end else if (REQ_WIDE) begin
            column_strobe_low_next = 1'b0;
            wrh_next  = ~(REQ_WRITE & REQ_HI);
            wrl_next  = ~(REQ_WRITE & REQ_LO);
          end else begin
            column_strobe_low_next = 1'b0;
            wrl_next  = ~REQ_WRITE;
          end
        end
      end
      S_PRE: begin
        ras_next = 1'b1;
        if (cnt_reg == 2'h0) begin
          state_next = S_IDLE;
        end else begin
          cnt_next = cnt_reg - 2'h1;
        end
      end
      S_ROW: begin
        state_next = S_COL;
        open_next  = 1'b1;
        ras_next   = 1'b0;
        addr_next  = REQ_ADDR;
        if (REQ_WIDE & ~dual_we) begin
          column_strobe_high_next = ~REQ_HI;
          column_strobe_low_next = ~REQ_LO;
          wrl_next  = ~REQ_WRITE;
        end else if (REQ_WIDE) begin
          column_strobe_low_next = 1'b0;
          wrh_next  = ~(REQ_WRITE & REQ_HI);
          wrl_next  = ~(REQ_WRITE & REQ_LO);
        end else begin
          column_strobe_low_next = 1'b0;
          wrl_next  = ~REQ_WRITE;
        end
      end
      S_COL: begin
        state_next = S_IDLE;
        ack_next   = 1'b1;
        ras_next   = 1'b0;
      end
      S_CBRC: begin
        // no waits when disabled
        // The wait state S_CBRW always adds one, the counter adds the code.
        state_next = rwait_en ? S_CBRW : S_CBRR;
        column_strobe_low_next  = 1'b0;
        column_strobe_high_next  = 1'b0;
        ras_next   = 1'b0;
        cnt_next   = rwait_en ? rwait : 2'h0;
      end
      S_CBRW: begin
        state_next = S_CBRR;
        column_strobe_low_next  = 1'b0;
        column_strobe_high_next  = 1'b0;
        ras_next   = 1'b0;
      end
      S_CBRR: begin
        ras_next  = 1'b0;
        column_strobe_low_next = 1'b0;
        column_strobe_high_next = 1'b0;
        if (cnt_reg == 2'h0) begin
          state_next = S_PRE;
          cnt_next   = {1'b0, pre_long};
          ras_next   = 1'b1;
          column_strobe_low_next  = 1'b1;
          column_strobe_high_next  = 1'b1;
        end else begin
          cnt_next = cnt_reg - 2'h1;
        end
      end
      S_SELF: begin
        column_strobe_low_next = 1'b0;
        column_strobe_high_next = 1'b0;
        ras_next  = 1'b0;
        if (!want_self) begin
          state_next = S_PRE;
          cnt_next   = {1'b0, pre_long};
          ras_next   = 1'b1;
          column_strobe_low_next  = 1'b1;
          column_strobe_high_next  = 1'b1;
        end
      end
      default: begin
        state_next = S_PRE;
        cnt_next   = 2'h1;
        open_next  = 1'b0;
        ras_next   = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer and pin flip-flops
  // ****************************************************************
  always @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state_reg      <= S_IDLE;
      cnt_reg        <= 2'h0;
      open_reg       <= 1'b0;
      row_reg        <= {ADDR_W{1'b0}};
      ACK            <= 1'b0;
      RAS_N          <= 1'b1;
      COLUMN_STROBE_HIGH_N         <= 1'b1;
      COLUMN_STROBE_LOW_N         <= 1'b1;
      WRH_N          <= 1'b1;
      WRL_N          <= 1'b1;
      DRAM_ADDR      <= {ADDR_W{1'b0}};
      CAS_SHORT_DUTY <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      open_reg  <= open_next;
      if (state_next == S_ROW) begin
        row_reg <= REQ_ADDR;
      end
      ACK       <= ack_next;
      RAS_N     <= ras_next;
      COLUMN_STROBE_HIGH_N    <= column_strobe_high_next;
      COLUMN_STROBE_LOW_N    <= column_strobe_low_next;
      WRH_N     <= wrh_next;
      WRL_N     <= wrl_next;
      DRAM_ADDR <= addr_next;
      // column strobe duty select
      // The sub-state edge lies in the pad cell; only the choice is timed here.
      CAS_SHORT_DUTY <= dram_en & cas_duty;
    end
  end

endmodule // dram_ctl

// ==== tb/dram_ctl_props.sv ====
// Concurrent checks on the DRAM control block, seen from its ports only.
// Assumes the register map of the design header and an Avalon master that
// releases its request at the edge where waitrequest is sampled low.
`timescale 1ns/1ps

// ****************************************************************
// Module dram_ctl_props
// ****************************************************************
module dram_ctl_props (
  input wire        REF_CLK,
  input wire        RESET_N,
  input wire [3:0]  ADDRESS,
  input wire        READ,
  input wire        WRITE,
  input wire [31:0] WRITEDATA,
  input wire [3:0]  BYTEENABLE,
  input wire [31:0] READDATA,
  input wire        WAITREQUEST,
  input wire        REQ,
  input wire        REQ_WIDE,
  input wire        ACK,
  input wire        RAS_N,
  input wire        COLUMN_STROBE_HIGH_N,
  input wire        COLUMN_STROBE_LOW_N,
  input wire        WRH_N,
  input wire        WRL_N,
  input wire        CAS_SHORT_DUTY
);
  // Shadows of the few control bits the properties depend on.
  reg  en_reg;
  reg  rfe_reg;
  reg  cw2_reg;
  reg  row_strobe_hold_low_reg;
  wire wr_done = WRITE && !WAITREQUEST;

  always @(posedge REF_CLK) begin
    if (!RESET_N) begin
      en_reg   <= 1'h0;
      rfe_reg  <= 1'h0;
      cw2_reg  <= 1'h0;
      row_strobe_hold_low_reg <= 1'h0;
    end else if (wr_done) begin
      if (ADDRESS[3:2] == 2'h2 && BYTEENABLE[0])
        en_reg <= WRITEDATA[0];
      if (ADDRESS[3:2] == 2'h0 && BYTEENABLE[1])
        cw2_reg <= WRITEDATA[15];
      if (ADDRESS[3:2] == 2'h0 && BYTEENABLE[1])
        row_strobe_hold_low_reg <= WRITEDATA[14];
      if (ADDRESS[3:2] == 2'h1 && BYTEENABLE[1:0] == 2'h3 && WRITEDATA[15:8] == 8'h5A)
        rfe_reg <= WRITEDATA[7];
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  a_ack_pulse: assert property (ACK |=> !ACK)
    else $error("ack stands longer than one cycle");
  a_bus_answer: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST)
    else $error("register access not answered in the next cycle");
  a_rsvd_zero: assert property (READ && !WAITREQUEST && ADDRESS[3:2] == 2'h0
    |-> READDATA[7:0] == 8'h00 && READDATA[31:16] == 16'h0000)
    else $error("reserved area control bits read nonzero");
  a_off_quiet: assert property (!en_reg && !rfe_reg
    |=> RAS_N && COLUMN_STROBE_LOW_N && COLUMN_STROBE_HIGH_N && WRL_N && !CAS_SHORT_DUTY)
    else $error("strobes or duty active while dram disabled");
  a_off_ack: assert property (!en_reg && !rfe_reg && REQ && !ACK |=> ACK)
    else $error("disabled request not acknowledged next cycle");
  a_ras_up: assert property (en_reg && !row_strobe_hold_low_reg && !rfe_reg && ACK |-> ##[1:3] RAS_N)
    else $error("row strobe not returned high after access");
  a_ras_down: assert property (en_reg && row_strobe_hold_low_reg && !rfe_reg && ACK |=> !RAS_N)
    else $error("row strobe not held low after access");
  a_dual_cas: assert property (en_reg && !rfe_reg && !cw2_reg |-> WRH_N)
    else $error("high write strobe used in dual column strobe mode");
  a_dual_we: assert property (en_reg && !rfe_reg && cw2_reg |-> COLUMN_STROBE_HIGH_N)
    else $error("high column strobe used in dual write strobe mode");
  a_narrow_lane: assert property (en_reg && !rfe_reg && REQ && !REQ_WIDE |-> COLUMN_STROBE_HIGH_N && WRH_N)
    else $error("high strobes used on 8-bit access");
  a_ack_bound: assert property (en_reg && !rfe_reg && REQ && !ACK |-> ##[1:8] ACK)
    else $error("dram access not acknowledged in time");
endmodule // dram_ctl_props

bind dram_ctl dram_ctl_props u_props (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDRESS(ADDRESS), .READ(READ),
  .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
  .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .REQ(REQ), .REQ_WIDE(REQ_WIDE),
  .ACK(ACK), .RAS_N(RAS_N), .COLUMN_STROBE_HIGH_N(COLUMN_STROBE_HIGH_N), .COLUMN_STROBE_LOW_N(COLUMN_STROBE_LOW_N), .WRH_N(WRH_N),
  .WRL_N(WRL_N), .CAS_SHORT_DUTY(CAS_SHORT_DUTY));

// ==== tb/dram_model.sv ====
// Behavioural DRAM observer: counts row opens, latches the row address,
// collects which strobes went low and times CAS-before-RAS row strobes.
// Assumes registered strobes that change just after the rising clock edge.
`timescale 1ns/1ps

// ****************************************************************
// Module dram_model
// ****************************************************************
module dram_model (
  input  wire        REF_CLK,
  input  wire        CLR,
  input  wire        RAS_N,
  input  wire        COLUMN_STROBE_HIGH_N,
  input  wire        COLUMN_STROBE_LOW_N,
  input  wire        WRH_N,
  input  wire        WRL_N,
  input  wire [27:0] DRAM_ADDR,
  output reg  [3:0]  seen,
  output reg  [3:0]  opens,
  output reg  [27:0] row,
  output reg  [4:0]  cbr_len
);
  reg        ras_d = 1'h1;
  reg        cas_d = 1'h1;
  reg        cbr   = 1'h0;
  reg [27:0] addr_d;

  // The row is latched from the address driven before the strobe falls,
  // as a real part would; a column strobe already low marks a refresh.
  always @(posedge REF_CLK) begin
    ras_d  <= RAS_N;
    cas_d  <= COLUMN_STROBE_LOW_N;
    addr_d <= DRAM_ADDR;
    if (CLR) begin
      seen    <= 4'h0;
      opens   <= 4'h0;
      cbr_len <= 5'h00;
      cbr     <= 1'h0;
    end else begin
      seen <= seen | ~{COLUMN_STROBE_HIGH_N, COLUMN_STROBE_LOW_N, WRH_N, WRL_N};
      if (ras_d && !RAS_N && cas_d) begin
        opens <= opens + 4'h1;
        row   <= addr_d;
      end
      if (ras_d && !RAS_N && !cas_d) begin
        cbr     <= 1'h1;
        cbr_len <= 5'h01;
      end else if (cbr && !RAS_N) begin
        cbr_len <= cbr_len + 5'h01;
      end
      if (RAS_N)
        cbr <= 1'h0;
    end
  end
endmodule // dram_model

// ==== tb/tb_dram_control_and_refresh_config.sv ====
// Self-checking bench for the DRAM control block: register bus, strobes,
// burst compare, address multiplexing and refresh timing.
// Assumes the design's register map and the DRAM observer model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin $display("ERROR %s expected %h seen %h", n, e, g); err_count++; end end

// ****************************************************************
// Module tb_dram_control_and_refresh_config
// ****************************************************************
module tb_dram_control_and_refresh_config;
  localparam [27:0] A = 28'hABCDEF0;
  reg REF_CLK, RESET_N, READ, WRITE, REQ, REQ_WRITE, REQ_WIDE, REQ_HI, REQ_LO;
  reg REFRESH_MATCH, CLR;
  reg [3:0] ADDRESS, BYTEENABLE;
  reg [31:0] WRITEDATA;
  reg [27:0] REQ_ADDR;
  wire [31:0] READDATA;
  wire [27:0] DRAM_ADDR, row;
  wire WAITREQUEST, ACK, RAS_N, COLUMN_STROBE_HIGH_N, COLUMN_STROBE_LOW_N, WRH_N, WRL_N, CAS_SHORT_DUTY;
  wire [3:0] seen, opens;
  wire [4:0] cbr_len, base;
  reg  [4:0] base_reg;
  integer err_count = 0;
  integer checks = 0;
  integer c;
  assign base = base_reg;

  dram_ctl dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .REQ(REQ), .REQ_ADDR(REQ_ADDR), .REQ_WRITE(REQ_WRITE),
    .REQ_WIDE(REQ_WIDE), .REQ_HI(REQ_HI), .REQ_LO(REQ_LO), .ACK(ACK),
    .REFRESH_MATCH(REFRESH_MATCH), .RAS_N(RAS_N), .COLUMN_STROBE_HIGH_N(COLUMN_STROBE_HIGH_N), .COLUMN_STROBE_LOW_N(COLUMN_STROBE_LOW_N),
    .WRH_N(WRH_N), .WRL_N(WRL_N), .DRAM_ADDR(DRAM_ADDR), .CAS_SHORT_DUTY(CAS_SHORT_DUTY));
  dram_model mem (.REF_CLK(REF_CLK), .CLR(CLR), .RAS_N(RAS_N), .COLUMN_STROBE_HIGH_N(COLUMN_STROBE_HIGH_N),
    .COLUMN_STROBE_LOW_N(COLUMN_STROBE_LOW_N), .WRH_N(WRH_N), .WRL_N(WRL_N), .DRAM_ADDR(DRAM_ADDR), .seen(seen),
    .opens(opens), .row(row), .cbr_len(cbr_len));

  // ****************************************************************
  // Bus and request tasks
  // ****************************************************************
  task bw(input [1:0] w, input [31:0] d, input [3:0] be);
    begin
      @(posedge REF_CLK);
      ADDRESS <= {w, 2'h0};
      WRITEDATA <= d;
      BYTEENABLE <= be;
      WRITE <= 1'h1;
      @(posedge REF_CLK);
      while (WAITREQUEST !== 1'h0) @(posedge REF_CLK);
      WRITE <= 1'h0;
    end
  endtask
  task rd(input [1:0] w, input [31:0] e);
    begin
      @(posedge REF_CLK);
      ADDRESS <= {w, 2'h0};
      READ <= 1'h1;
      @(posedge REF_CLK);
      while (WAITREQUEST !== 1'h0) @(posedge REF_CLK);
      READ <= 1'h0;
      `CHK("readdata", e, READDATA)
    end
  endtask
  task acc(input [27:0] a, input [3:0] f);
    begin
      @(posedge REF_CLK);
      REQ <= 1'h1;
      REQ_ADDR <= a;
      {REQ_WIDE, REQ_HI, REQ_LO, REQ_WRITE} <= f;
      @(posedge REF_CLK);
      while (ACK !== 1'h1) @(posedge REF_CLK);
      REQ <= 1'h0;
      repeat (6) @(posedge REF_CLK);
    end
  endtask
  task clr;
    begin
      @(posedge REF_CLK);
      CLR <= 1'h1;
      @(posedge REF_CLK);
      CLR <= 1'h0;
    end
  endtask
  task refresh_run;
    begin
      clr;
      @(posedge REF_CLK);
      REFRESH_MATCH <= 1'h1;
      @(posedge REF_CLK);
      REFRESH_MATCH <= 1'h0;
      repeat (24) @(posedge REF_CLK);
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task st(input [15:0] area, input [3:0] f, input [3:0] e);
    begin
      bw(2'h0, {16'h0000, area}, 4'h2);
      clr;
      acc(28'h0123456, f);
      `CHK("strobes", e, seen)
      `CHK("opens", 4'h1, opens)
    end
  endtask
  task pair(input [15:0] area, input [27:0] delta, input [3:0] e);
    begin
      bw(2'h0, {16'h0000, area}, 4'h2);
      acc(A, 4'hB);
      clr;
      acc(A ^ delta, 4'hB);
      `CHK("row_opens", e, opens)
      `CHK("duty", area[11], CAS_SHORT_DUTY)
    end
  endtask
  task mx(input [15:0] area, input [27:0] e);
    begin
      bw(2'h0, {16'h0000, area}, 4'h2);
      clr;
      acc(A, 4'hA);
      `CHK("row_addr", e, row)
    end
  endtask

  task results;
    begin
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  initial begin
    REF_CLK = 1'h0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  initial begin
    #2000000;
    err_count++;
    results;
  end

  initial begin
    {RESET_N, READ, WRITE, REQ, REQ_WRITE, REQ_WIDE, REQ_HI, REQ_LO} = 8'h00;
    {REFRESH_MATCH, CLR, ADDRESS, BYTEENABLE, WRITEDATA, REQ_ADDR} = 70'h0;
    base_reg = 5'h00;
    repeat (2) @(posedge REF_CLK);
    RESET_N <= 1'h1;
    rd(2'h0, 32'h0);
    rd(2'h1, 32'h0);
    rd(2'h2, 32'h0);
    bw(2'h0, 32'hFFFFFFFF, 4'hF);
    rd(2'h0, 32'h0000FF00);
    bw(2'h1, 32'h000000F0, 4'h3);
    rd(2'h1, 32'h0);
    bw(2'h1, 32'h00005AF0, 4'h1);
    rd(2'h1, 32'h0);
    // Self-refresh entered, then left with refresh kept enabled.
    bw(2'h1, 32'h00005AFF, 4'h3);
    rd(2'h1, 32'h000000F0);
    bw(2'h1, 32'h00005A80, 4'h3);
    rd(2'h1, 32'h00000080);
    bw(2'h1, 32'h00005A00, 4'h3);
    bw(2'h2, 32'h00000001, 4'hF);
    st(16'h0000, 4'hD, 4'h9);
    st(16'h0000, 4'hA, 4'h4);
    st(16'h8000, 4'hD, 4'h6);
    st(16'h8000, 4'h7, 4'h5);
    pair(16'h4000, 28'h0000001, 4'h1);
    pair(16'h6000, 28'h0000001, 4'h1);
    pair(16'h7800, 28'h0000001, 4'h0);
    pair(16'h5000, 28'h0000100, 4'h1);
    pair(16'h5100, 28'h0000100, 4'h0);
    pair(16'h5200, 28'h0000200, 4'h0);
    pair(16'h5200, 28'h0000400, 4'h1);
    mx(16'h0000, A);
    mx(16'h0400, A >> 8);
    mx(16'h0500, A >> 9);
    mx(16'h0600, A >> 10);
    refresh_run;
    `CHK("cbr_off", 5'h00, cbr_len)
    bw(2'h1, 32'h00005AB0, 4'h3);
    refresh_run;
    base_reg = cbr_len;
    `CHK("cbr_seen", 1'h1, base != 5'h00)
    bw(2'h2, 32'h00000003, 4'hF);
    for (c = 0; c < 4; c++) begin
      bw(2'h1, 32'h00005A80 | (c << 4), 4'h3);
      refresh_run;
      `CHK("cbr_wait", base + c[4:0] + 5'h01, cbr_len)
    end
    bw(2'h1, 32'h00005A00, 4'h3);
    bw(2'h2, 32'h00000000, 4'hF);
    acc(A, 4'hB);
    results;
  end
endmodule // tb_dram_control_and_refresh_config
